// ===== logic/tam_filter.sv
// Synchroniser and glitch filter for one tamper input.
`timescale 1ns/100ps
module tam_filter #(
  parameter int unsigned FILTER_CYCLES = tam_pkg::GLITCH_CYCLES,
  parameter logic IDLE = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic tamper
);

  localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(FILTER_CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic sync_a;
  logic sync_b;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_tamper;
  logic active;

  // Counts cycles at the tamper level; accepts only after the full run.
  always_comb begin
    active = (sync_b != IDLE);
    next_count = count;
    next_tamper = tamper;
    if (active) begin
      if (count == LIMIT) begin
        next_tamper = 1'b1; // see R2, see R17
      end else begin
        next_count = count + ONE;
      end
    end else begin
      next_count = '0;
      next_tamper = 1'b0;
    end
  end

  // Two-stage synchroniser and filter registers.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_a <= IDLE;
      sync_b <= IDLE;
      count <= '0;
      tamper <= 1'b0;
    end else begin
      sync_a <= pin; // see R17
      sync_b <= sync_a;
      count <= next_count;
      tamper <= next_tamper;
    end
  end

endmodule : tam_filter

// ===== logic/tam_monitor.sv
// Tamper alarm monitor: input filters, arming sequence, alarm and supply switch.
`timescale 1ns/100ps
// Behaviour
// R1 - Four tamper inputs, two high-idle, two low-idle.
// R2 - Each input filtered against short glitches.
// R3 - First and third inputs flag when low.
// R4 - Second and fourth inputs flag when high.
// R5 - Any tamper drives alarm low.
// R6 - Alarm releases once no condition remains.
// R7 - Monitor selected internal supply continuously.
// R8 - Alarm while supply above over-voltage trip.
// R9 - Alarm while supply below under-voltage trip.
// R10 - Alarm on tamper for every variant.
// R11 - Switched supply on, high-Z or ground.
// R12 - Alarms disabled until first power-up time-out.
// R13 - Armed detection works on main or battery.
// R14 - Timer holds reset for time-out after threshold.
// R15 - Timer clears below threshold, restarts above.
// R16 - Armed state sticky until supply lost.
// R17 - Inputs synchronised, accepted after consecutive cycles.
module tam_monitor #(
  parameter int unsigned FILTER_CYCLES = tam_pkg::GLITCH_CYCLES,
  parameter int unsigned TIMEOUT_CYCLES = tam_pkg::RESET_TIMEOUT_CYCLES,
  parameter tam_pkg::tam_variant_t VARIANT = tam_pkg::TAM_OUT_ON
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic high_idle_tamper_a,
  input wire logic low_idle_tamper_a,
  input wire logic high_idle_tamper_b,
  input wire logic low_idle_tamper_b,
  input wire logic main_above_reset,
  input wire logic supply_present,
  input wire logic overvoltage_trip,
  input wire logic undervoltage_trip,
  input wire logic on_battery,
  output logic security_alarm_n,
  output logic security_alarm_oe,
  output logic reset_n,
  output logic armed,
  output logic [tam_pkg::NUM_TAMPER-1:0] tamper_seen,
  output logic switched_supply_connect,
  output logic switched_supply_ground
);

  localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TLIMIT = TW'(TIMEOUT_CYCLES);
  localparam logic [TW-1:0] TONE = TW'(1);

  logic [tam_pkg::NUM_TAMPER-1:0] pins;
  logic [tam_pkg::NUM_TAMPER-1:0] tamper;
  tam_pkg::tam_supply_t sup_a;
  tam_pkg::tam_supply_t sup;
  tam_pkg::tam_supply_t next_sup;
  logic bat_a;
  logic bat;
  tam_pkg::tam_state_t state;
  tam_pkg::tam_state_t next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic next_reset_n;
  logic fault;
  logic next_alarm_n;
  tam_pkg::tam_switch_t sw;
  tam_pkg::tam_switch_t next_sw;

  // True once the arming sequence has completed; used by the alarm and the status port.
  function automatic logic is_armed(input tam_pkg::tam_state_t st);
    return (st == tam_pkg::TAM_ST_ARMED);
  endfunction : is_armed

  // Gather the four pins in order, first input in bit 0.
  assign pins = {low_idle_tamper_b, high_idle_tamper_b, low_idle_tamper_a,
                 high_idle_tamper_a}; // see R1

  // One filter per input, idle level taken from the package mask.
  generate
    for (genvar i = 0; i < tam_pkg::NUM_TAMPER; i++) begin : g_filt
      tam_filter #(
        .FILTER_CYCLES(FILTER_CYCLES),
        .IDLE(tam_pkg::IDLE_LEVEL[i]) // see R3, see R4
      ) u_filt (
        .clk(clk),
        .nrst(nrst),
        .pin(pins[i]),
        .tamper(tamper[i]) // see R2
      );
    end
  endgenerate

  // Supply flags come from analog comparators; pass them through two flops.
  always_comb begin
    next_sup = sup_a; // see R7
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sup_a <= '0;
      sup <= '0;
      bat_a <= 1'b0;
      bat <= 1'b0;
    end else begin
      sup_a <= {main_above_reset, supply_present, overvoltage_trip, undervoltage_trip};
      sup <= next_sup;
      bat_a <= on_battery;
      bat <= bat_a;
    end
  end

  // Arming sequence: wait for main above threshold, time out, then stay armed.
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_reset_n = 1'b0;
    unique case (state)
      tam_pkg::TAM_ST_OFF: begin
        next_timer = '0;
        if (sup.main_above_reset) begin
          next_state = tam_pkg::TAM_ST_WAIT; // see R12
        end
      end
      tam_pkg::TAM_ST_WAIT: begin
        if (!sup.main_above_reset) begin
          next_timer = '0; // see R15
          next_state = tam_pkg::TAM_ST_OFF;
        end else if (timer == TLIMIT) begin
          next_state = tam_pkg::TAM_ST_ARMED; // see R14
          next_reset_n = 1'b1;
        end else begin
          next_timer = timer + TONE; // see R14
        end
      end
      tam_pkg::TAM_ST_ARMED: begin
        // Reset output follows the main supply with its own time-out again.
        if (!sup.main_above_reset) begin
          next_timer = '0; // see R15
        end else if (timer == TLIMIT) begin
          next_reset_n = 1'b1;
        end else begin
          next_timer = timer + TONE; // see R15
        end
        if (!sup.supply_present) begin
          next_state = tam_pkg::TAM_ST_OFF; // see R16
          next_timer = '0;
          next_reset_n = 1'b0;
        end
      end
      default: begin
        next_state = tam_pkg::TAM_ST_OFF;
        next_timer = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= tam_pkg::TAM_ST_OFF;
      timer <= '0;
      reset_n <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      reset_n <= next_reset_n;
    end
  end

  // Alarm is a level: any filtered tamper or supply fault while armed.
  always_comb begin
    fault = (|tamper) || sup.over_voltage || sup.under_voltage; // see R5, see R8, see R9
    // Armed state ignores which supply is in use.
    next_alarm_n = !(fault && is_armed(state)); // see R6, see R10, see R12, see R13
    next_sw.connect = 1'b1;
    next_sw.ground = 1'b0;
    if (!next_alarm_n) begin
      unique case (VARIANT)
        tam_pkg::TAM_OUT_ON: begin
          next_sw.connect = 1'b1; // see R11
        end
        tam_pkg::TAM_OUT_HIGHZ: begin
          next_sw.connect = 1'b0; // see R11
        end
        tam_pkg::TAM_OUT_GROUND: begin
          next_sw.connect = 1'b0;
          next_sw.ground = 1'b1; // see R11
        end
        default: begin
          next_sw.connect = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      security_alarm_n <= 1'b1;
      sw <= '{connect: 1'b1, ground: 1'b0};
      tamper_seen <= '0;
    end else begin
      security_alarm_n <= next_alarm_n;
      sw <= next_sw;
      tamper_seen <= tamper;
    end
  end

  // Open-drain alarm: drive only while low.
  assign security_alarm_oe = !security_alarm_n;
  assign armed = is_armed(state);
  assign switched_supply_connect = sw.connect;
  assign switched_supply_ground = sw.ground;

endmodule : tam_monitor

// ===== logic/tam_pkg.sv
// Package with shared types and constants of the tamper alarm monitor.
package tam_pkg;

  // Number of physical tamper inputs.
  localparam int unsigned NUM_TAMPER = 4;

  // Glitch immunity time in nanoseconds and the clock period it is counted in.
  localparam int unsigned GLITCH_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset time-out in microseconds, and its length in cycles.
  localparam int unsigned RESET_TIMEOUT_US = 140;
  localparam int unsigned RESET_TIMEOUT_CYCLES = (RESET_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  // Idle level of each tamper input, index 0 is the first input.
  localparam logic [NUM_TAMPER-1:0] IDLE_LEVEL = 4'h5;

  // Variant choice of the switched supply output during an alarm.
  typedef enum logic [1:0] {
    TAM_OUT_ON = 2'h0,
    TAM_OUT_HIGHZ = 2'h1,
    TAM_OUT_GROUND = 2'h2
  } tam_variant_t;

  // Arming sequence states, one-hot.
  typedef enum logic [2:0] {
    TAM_ST_OFF = 3'h1,
    TAM_ST_WAIT = 3'h2,
    TAM_ST_ARMED = 3'h4
  } tam_state_t;

  // Supply condition seen by the block.
  typedef struct packed {
    logic main_above_reset;
    logic supply_present;
    logic over_voltage;
    logic under_voltage;
  } tam_supply_t;

  // Controls of the switched supply output switch.
  typedef struct packed {
    logic connect;
    logic ground;
  } tam_switch_t;

endpackage : tam_pkg

// ===== testbench/tam_env.sv
// Model of the tamper switches and supply comparators around the monitor.
`timescale 1ns/100ps
module tam_env (
  input wire logic [3:0] cut,
  input wire logic main_on,
  input wire logic bat_on,
  input wire logic [7:0] volts,
  output logic [3:0] pins,
  output logic main_above_reset,
  output logic supply_present,
  output logic overvoltage_trip,
  output logic undervoltage_trip,
  output logic on_battery
);
  // A cut switch moves its pin off the idle level; volts are in tenths.
  assign pins = tam_pkg::IDLE_LEVEL ^ cut;
  assign main_above_reset = main_on;
  assign supply_present = main_on | bat_on;
  assign on_battery = bat_on & !main_on;
  assign overvoltage_trip = supply_present && volts > 8'h2a;
  assign undervoltage_trip = supply_present && volts < 8'h14;
endmodule : tam_env

// ===== testbench/tam_monitor_assertions.sv
// Port checker of the tamper alarm monitor.
`timescale 1ns/100ps
module tam_monitor_assertions #(
  parameter int unsigned TIMEOUT_CYCLES = tam_pkg::RESET_TIMEOUT_CYCLES,
  parameter tam_pkg::tam_variant_t VARIANT = tam_pkg::TAM_OUT_ON
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic main_above_reset,
  input wire logic supply_present,
  input wire logic overvoltage_trip,
  input wire logic undervoltage_trip,
  input wire logic security_alarm_n,
  input wire logic reset_n,
  input wire logic armed,
  input wire logic [tam_pkg::NUM_TAMPER-1:0] tamper_seen,
  input wire logic switched_supply_connect,
  input wire logic switched_supply_ground
);
  // Switch controls that the variant asks for while the alarm is low.
  localparam logic [1:0] SW = (VARIANT == tam_pkg::TAM_OUT_ON) ? 2'h2 :
    (VARIANT == tam_pkg::TAM_OUT_GROUND) ? 2'h1 : 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Counts how many cycles in a row the main supply has stood above the threshold.
  int unsigned main_run;
  always_ff @(posedge clk) begin
    if (!nrst || !main_above_reset) begin
      main_run <= 32'd0;
    end else begin
      main_run <= main_run + 32'd1;
    end
  end
  property p_unarmed; !armed [*2] |-> security_alarm_n; endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed alarm");
  property p_tamper; (armed && tamper_seen != 4'h0) [*2] |-> !security_alarm_n; endproperty
  a_tamper: assert property (p_tamper) else $error("tamper no alarm");
  property p_over; (armed && overvoltage_trip) [*3] |=> !security_alarm_n; endproperty
  a_over: assert property (p_over) else $error("over no alarm");
  property p_under; (armed && undervoltage_trip) [*3] |=> !security_alarm_n; endproperty
  a_under: assert property (p_under) else $error("under no alarm");
  property p_clear;
    (!overvoltage_trip && !undervoltage_trip && tamper_seen == 4'h0) [*4] |-> security_alarm_n;
  endproperty
  a_clear: assert property (p_clear) else $error("alarm stuck");
  property p_switch;
    {switched_supply_connect, switched_supply_ground} == (security_alarm_n ? 2'h2 : SW);
  endproperty
  a_switch: assert property (p_switch) else $error("switch state");
  property p_timeout; $rose(reset_n) |-> main_run > TIMEOUT_CYCLES; endproperty
  a_timeout: assert property (p_timeout) else $error("early reset release");
  property p_rst_low; !main_above_reset [*3] |=> !reset_n; endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset not held");
  property p_sticky; (armed && supply_present) [*3] |=> armed; endproperty
  a_sticky: assert property (p_sticky) else $error("disarmed");
endmodule : tam_monitor_assertions
bind tam_monitor tam_monitor_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .VARIANT(VARIANT))
  chk_u (.clk, .nrst, .main_above_reset, .supply_present, .overvoltage_trip,
  .undervoltage_trip, .security_alarm_n, .reset_n, .armed, .tamper_seen,
  .switched_supply_connect, .switched_supply_ground);

// ===== testbench/tb_tam_monitor.sv
// Self-checking bench of the tamper alarm monitor.
`timescale 1ns/100ps
module tb_tam_monitor;
  localparam int unsigned TO = 10;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] cut = 4'h0;
  logic main_on = 1'b0;
  logic bat_on = 1'b1;
  logic [7:0] volts = 8'h1e;
  logic [3:0] pins, tamper_seen;
  logic main_above_reset, supply_present, overvoltage_trip, undervoltage_trip, on_battery;
  logic security_alarm_n, security_alarm_oe, reset_n, armed;
  logic switched_supply_connect, switched_supply_ground;
  logic [1:0] sw_on, sw_hz;
  logic last = 1'b1;
  logic q[$];
  int errors = 0, num_checks = 0, seed = 86, k;
  wire logic [2:0] sw = {security_alarm_oe, switched_supply_connect, switched_supply_ground};
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  tam_env env_u (.cut, .main_on, .bat_on, .volts, .pins, .main_above_reset, .supply_present,
    .overvoltage_trip, .undervoltage_trip, .on_battery);
  tam_monitor #(.FILTER_CYCLES(3), .TIMEOUT_CYCLES(TO), .VARIANT(tam_pkg::TAM_OUT_GROUND))
    dut_u (.clk, .nrst, .high_idle_tamper_a(pins[0]), .low_idle_tamper_a(pins[1]),
    .high_idle_tamper_b(pins[2]), .low_idle_tamper_b(pins[3]), .main_above_reset,
    .supply_present, .overvoltage_trip, .undervoltage_trip, .on_battery, .security_alarm_n,
    .security_alarm_oe, .reset_n, .armed, .tamper_seen, .switched_supply_connect,
    .switched_supply_ground);
  // Two more monitors on the same pins cover the remaining switch variants.
  tam_monitor #(.FILTER_CYCLES(3), .TIMEOUT_CYCLES(TO), .VARIANT(tam_pkg::TAM_OUT_ON))
    dut_on_u (.clk, .nrst, .high_idle_tamper_a(pins[0]), .low_idle_tamper_a(pins[1]),
    .high_idle_tamper_b(pins[2]), .low_idle_tamper_b(pins[3]), .main_above_reset,
    .supply_present, .overvoltage_trip, .undervoltage_trip, .on_battery, .security_alarm_n(),
    .security_alarm_oe(), .reset_n(), .armed(), .tamper_seen(),
    .switched_supply_connect(sw_on[1]), .switched_supply_ground(sw_on[0]));
  tam_monitor #(.FILTER_CYCLES(3), .TIMEOUT_CYCLES(TO), .VARIANT(tam_pkg::TAM_OUT_HIGHZ))
    dut_hz_u (.clk, .nrst, .high_idle_tamper_a(pins[0]), .low_idle_tamper_a(pins[1]),
    .high_idle_tamper_b(pins[2]), .low_idle_tamper_b(pins[3]), .main_above_reset,
    .supply_present, .overvoltage_trip, .undervoltage_trip, .on_battery, .security_alarm_n(),
    .security_alarm_oe(), .reset_n(), .armed(), .tamper_seen(),
    .switched_supply_connect(sw_hz[1]), .switched_supply_ground(sw_hz[0]));
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  // Holds a condition for n cycles and notes the alarm edges it should cause.
  task evt(input logic [3:0] c, input logic [7:0] v, input int n, input logic hit);
    cut = c;
    volts = v;
    if (hit) q.push_back(1'b0);
    step(n);
    if (hit) chk(tamper_seen === c && sw === 3'h5 && sw_on === 2'h2 && sw_hz === 2'h0, "switch");
    cut = 4'h0;
    volts = 8'h1e;
    if (hit) q.push_back(1'b1);
    step(12);
    if (hit) chk(sw === 3'h2 && sw_on === 2'h2 && sw_hz === 2'h2, "release");
  endtask : evt
  // Each alarm edge takes the oldest expected level off the queue.
  always @(posedge clk) begin
    #2;
    if (nrst && security_alarm_n !== last) begin
      last = security_alarm_n;
      num_checks++;
      if (q.size() == 0 || q.pop_front() !== last) begin
        errors++;
        $display("mismatch at %0t: alarm edge", $time);
      end
    end
  end
  initial begin
    step(4);
    nrst = 1'b1;
    evt(4'h0, 8'h2d, 8, 1'b0);
    evt(4'h2, 8'h1e, 10, 1'b0);
    main_on = 1'b1;
    step(5);
    main_on = 1'b0;
    step(3);
    main_on = 1'b1;
    for (k = 0; k < 40 && reset_n !== 1'b1; k++)
      step(1);
    if (reset_n !== 1'b1) begin
      chk(1'b0, "arming timeout");
    end
    chk(k > TO && k < TO + 5 && armed === 1'b1, "arming");
    for (k = 0; k < 4; k++) begin
      evt(4'h1 << k, 8'h1e, 1 + $unsigned($random(seed)) % 3, 1'b0);
      evt(4'h1 << k, 8'h1e, 10, 1'b1);
    end
    evt(4'h0, 8'h2b + 8'($random(seed) & 7), 8, 1'b1);
    evt(4'h0, 8'h13 - 8'($random(seed) & 7), 8, 1'b1);
    main_on = 1'b0;
    step(10);
    chk(reset_n === 1'b0 && armed === 1'b1, "battery");
    evt(4'h0, 8'h10, 8, 1'b1);
    bat_on = 1'b0;
    step(6);
    chk(armed === 1'b0, "loss");
    bat_on = 1'b1;
    evt(4'h8, 8'h1e, 10, 1'b0);
    chk(q.size() == 0, "pending");
    summarize();
  end
endmodule : tb_tam_monitor
